/* hdl/flash_host_cfg.svh */
/*
 Offsets, field positions, reset values and timing counts for the
 flash status-polling controller. Assumes a 40 MHz system clock.
*/
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define CLK_PERIOD_NS 25
`define SYNC_STAGES 2
`define T_ACCESS_NS 120
`define T_WE_LOW_NS 50
`define T_RESET_LOW_NS 500
`define T_RESET_DONE_NS 20000
`define RD_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + `SYNC_STAGES)
`define WE_CYC ((`T_WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_LOW_CYC ((`T_RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_DONE_CYC ((`T_RESET_DONE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RESULT 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14

`define POLL_BIT 7
`define TOGGLE_BIT 6
`define FAIL_BIT 5
`define TIMER_BIT 3

`define IRQ_DONE 0
`define IRQ_FAIL 1
`define IRQ_REJECT 2
`define IRQ_W 3
`define IRQ_MASK_RESET 3'h0

`define SECTOR_ERASE_CMD 8'h30

`endif

/* hdl/flash_host_pkg.sv */
/*
 Types for the flash status-polling controller.
 Assumes flash_host_cfg.svh for all numeric values.
*/
package flash_host_pkg;

	typedef enum logic [2:0] {
		OP_WRITE = 3'h0,
		OP_READ = 3'h1,
		OP_POLL = 3'h2,
		OP_ADD_SECTOR = 3'h3,
		OP_RESET = 3'h4
	} op_t;

	typedef enum logic [3:0] {
		B_IDLE = 4'h1,
		B_SETUP = 4'h2,
		B_PULSE = 4'h4,
		B_HOLD = 4'h8
	} bus_state_t;

	typedef enum logic [9:0] {
		S_IDLE = 10'h001,
		S_RAW = 10'h002,
		S_POLL_FIRST = 10'h004,
		S_POLL_NEXT = 10'h008,
		S_FINAL = 10'h010,
		S_ADD_PRE = 10'h020,
		S_ADD_WR = 10'h040,
		S_ADD_POST = 10'h080,
		S_RST = 10'h100,
		S_RWAIT = 10'h200
	} ctrl_state_t;

endpackage

/* hdl/flash_bus_cycle.sv */
/*
 One asynchronous flash bus cycle (read or write) on the parallel pins.
 Assumes the caller issues start only while idle and waits for done.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

module flash_bus_cycle import flash_host_pkg::*; (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic write,
	input wire logic [19:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] dq_in,
	output logic [19:0] flash_addr,
	output logic [7:0] dq_out,
	output logic dq_oe,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [7:0] rdata,
	output logic done
);
	bus_state_t state, next_state;
	logic [3:0] cnt, next_cnt;
	logic is_wr, next_is_wr;
	logic [19:0] next_flash_addr;
	logic [7:0] next_dq_out, next_rdata, dq_meta, dq_sync;
	logic next_dq_oe, next_ce_n, next_oe_n, next_we_n, next_done;

	// Access time includes the two synchroniser stages
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_is_wr = is_wr;
		next_flash_addr = flash_addr;
		next_dq_out = dq_out;
		next_dq_oe = dq_oe;
		next_ce_n = ce_n;
		next_oe_n = oe_n;
		next_we_n = we_n;
		next_rdata = rdata;
		next_done = 1'b0;
		unique case (state)
			B_IDLE: if (start) begin
				next_state = B_SETUP;
				next_flash_addr = addr;
				next_dq_out = wdata;
				next_dq_oe = write;
				next_is_wr = write;
				next_ce_n = 1'b0;
			end
			B_SETUP: begin
				next_state = B_PULSE;
				if (is_wr) begin
					next_we_n = 1'b0;
					next_cnt = 4'(`WE_CYC - 1);
				end else begin
					next_oe_n = 1'b0;
					next_cnt = 4'(`RD_CYC - 1);
				end
			end
			B_PULSE: if (cnt == 4'h0) begin
				next_state = B_HOLD;
				next_we_n = 1'b1;
				next_oe_n = 1'b1;
				if (!is_wr) begin
					next_rdata = dq_sync;
				end
			end else begin
				next_cnt = cnt - 4'h1;
			end
			B_HOLD: begin
				// Data held past the rising write edge
				next_state = B_IDLE;
				next_ce_n = 1'b1;
				next_dq_oe = 1'b0;
				next_done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= B_IDLE;
			cnt <= 4'h0;
			is_wr <= 1'b0;
			flash_addr <= 20'h00000;
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			rdata <= 8'h00;
			done <= 1'b0;
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			is_wr <= next_is_wr;
			flash_addr <= next_flash_addr;
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
			ce_n <= next_ce_n;
			oe_n <= next_oe_n;
			we_n <= next_we_n;
			rdata <= next_rdata;
			done <= next_done;
			dq_meta <= dq_in;
			dq_sync <= dq_meta;
		end
	end

	no_contention_a: assert property (@(posedge clk) disable iff (!resetn)
		dq_oe |-> oe_n)
		else $error("data driven while flash outputs enabled");

endmodule // flash_bus_cycle
`default_nettype wire

/* hdl/flash_host_ctrl.sv */
/*
 Host controller that drives a parallel flash and polls its status flags.
 Assumes software on a plain register port and a flash on the pins.
*/
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

module flash_host_ctrl import flash_host_pkg::*; (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic IRQ,
	output logic [19:0] FLASH_ADDR,
	input wire logic [7:0] FLASH_DQ_IN,
	output logic [7:0] FLASH_DQ_OUT,
	output logic FLASH_DQ_OE,
	output logic FLASH_CE_N,
	output logic FLASH_OE_N,
	output logic FLASH_WE_N,
	output logic FLASH_RESET_N,
	input wire logic READY_BUSY_OUT
);
	ctrl_state_t state, next_state;
	logic [19:0] addr_reg, next_addr_reg, op_addr, next_op_addr;
	logic [7:0] wdata_reg, next_wdata_reg, bus_wdata, next_bus_wdata;
	logic [7:0] result, next_result, bus_rdata;
	logic [`IRQ_W-1:0] irq_st, next_irq_st, mask, next_mask, irq_set;
	logic [9:0] cnt, next_cnt;
	logic go, next_go, go_wr, next_go_wr, bus_done;
	logic locked, next_locked, accepted, next_accepted;
	logic prev_tog, next_prev_tog, fail_seen, next_fail_seen;
	logic pre_low, next_pre_low, rst_n_q, next_rst_n_q;
	logic rb_meta, rb_sync, next_irq;
	logic [31:0] next_rdata;
	logic ctrl_wr;
	op_t op;

	assign ctrl_wr = REG_WR && (REG_ADDR == `REG_CTRL);
	assign op = op_t'(REG_WDATA[2:0]);

	flash_bus_cycle bus (
		.clk(SYS_CLK),
		.resetn(RESETN),
		.start(go),
		.write(go_wr),
		.addr(op_addr),
		.wdata(bus_wdata),
		.dq_in(FLASH_DQ_IN),
		.flash_addr(FLASH_ADDR),
		.dq_out(FLASH_DQ_OUT),
		.dq_oe(FLASH_DQ_OE),
		.ce_n(FLASH_CE_N),
		.oe_n(FLASH_OE_N),
		.we_n(FLASH_WE_N),
		.rdata(bus_rdata),
		.done(bus_done)
	);

	always_comb begin
		next_state = state;
		next_addr_reg = addr_reg;
		next_wdata_reg = wdata_reg;
		next_mask = mask;
		next_op_addr = op_addr;
		next_bus_wdata = bus_wdata;
		next_result = result;
		next_cnt = cnt;
		next_go = 1'b0;
		next_go_wr = go_wr;
		next_locked = locked;
		next_accepted = accepted;
		next_prev_tog = prev_tog;
		next_fail_seen = fail_seen;
		next_pre_low = pre_low;
		next_rst_n_q = rst_n_q;
		irq_set = '0;
		if (REG_WR && REG_ADDR == `REG_ADDR) begin
			next_addr_reg = REG_WDATA[19:0];
		end
		if (REG_WR && REG_ADDR == `REG_WDATA) begin
			next_wdata_reg = REG_WDATA[7:0];
		end
		if (REG_WR && REG_ADDR == `REG_IRQ_MASK) begin
			next_mask = REG_WDATA[`IRQ_W-1:0];
		end
		unique case (state)
			S_IDLE: if (ctrl_wr) begin
				// Address frozen for the whole operation
				next_op_addr = addr_reg;
				next_bus_wdata = wdata_reg;
				next_go_wr = 1'b0;
				if (op == OP_RESET) begin
					next_rst_n_q = 1'b0;
					next_cnt = 10'(`RST_LOW_CYC - 1);
					next_state = S_RST;
				end else if (locked) begin
					irq_set[`IRQ_REJECT] = 1'b1;
				end else begin
					unique case (op)
						OP_WRITE: begin
							next_go = 1'b1;
							next_go_wr = 1'b1;
							next_state = S_RAW;
						end
						OP_READ: begin
							next_go = 1'b1;
							next_state = S_RAW;
						end
						OP_POLL: begin
							next_go = 1'b1;
							next_fail_seen = 1'b0;
							next_state = S_POLL_FIRST;
						end
						OP_ADD_SECTOR: begin
							next_go = 1'b1;
							next_state = S_ADD_PRE;
						end
						default: irq_set[`IRQ_REJECT] = 1'b1;
					endcase
				end
			end
			S_RAW: if (bus_done) begin
				next_result = bus_rdata;
				irq_set[`IRQ_DONE] = 1'b1;
				next_state = S_IDLE;
			end
			S_POLL_FIRST: if (bus_done) begin
				next_prev_tog = bus_rdata[`TOGGLE_BIT];
				next_go = 1'b1;
				next_state = S_POLL_NEXT;
			end
			S_POLL_NEXT: if (bus_done) begin
				next_result = bus_rdata;
				if (bus_rdata[`TOGGLE_BIT] == prev_tog) begin
					// Toggle stopped; other lines may lag
					next_go = 1'b1;
					next_state = S_FINAL;
				end else if (bus_rdata[`FAIL_BIT] && fail_seen) begin
					// Still toggling after the fail flag: give up
					next_locked = 1'b1;
					irq_set[`IRQ_FAIL] = 1'b1;
					next_state = S_IDLE;
				end else begin
					next_fail_seen = bus_rdata[`FAIL_BIT];
					next_prev_tog = bus_rdata[`TOGGLE_BIT];
					next_go = 1'b1;
				end
			end
			S_FINAL: if (bus_done) begin
				next_result = bus_rdata;
				irq_set[`IRQ_DONE] = 1'b1;
				next_state = S_IDLE;
			end
			S_ADD_PRE: if (bus_done) begin
				next_pre_low = !bus_rdata[`TIMER_BIT];
				next_bus_wdata = `SECTOR_ERASE_CMD;
				next_go = 1'b1;
				next_go_wr = 1'b1;
				next_state = S_ADD_WR;
			end
			S_ADD_WR: if (bus_done) begin
				next_go = 1'b1;
				next_go_wr = 1'b0;
				next_state = S_ADD_POST;
			end
			S_ADD_POST: if (bus_done) begin
				next_result = bus_rdata;
				next_accepted = pre_low && !bus_rdata[`TIMER_BIT];
				if (pre_low && !bus_rdata[`TIMER_BIT]) begin
					irq_set[`IRQ_DONE] = 1'b1;
				end else begin
					irq_set[`IRQ_REJECT] = 1'b1;
				end
				next_state = S_IDLE;
			end
			S_RST: if (cnt == 10'h000) begin
				next_rst_n_q = 1'b1;
				next_cnt = 10'(`RST_DONE_CYC - 1);
				next_state = S_RWAIT;
			end else begin
				next_cnt = cnt - 10'h001;
			end
			S_RWAIT: if (cnt != 10'h000) begin
				next_cnt = cnt - 10'h001;
			end else if (rb_sync) begin
				// Reset done: failure cleared
				next_locked = 1'b0;
				irq_set[`IRQ_DONE] = 1'b1;
				next_state = S_IDLE;
			end
		endcase
		// A new event wins over a write-one clear in the same cycle
		next_irq_st = irq_st | irq_set;
		if (REG_WR && REG_ADDR == `REG_IRQ_STAT) begin
			next_irq_st = (irq_st & ~REG_WDATA[`IRQ_W-1:0]) | irq_set;
		end
		next_irq = |(irq_st & mask);
		next_rdata = 32'h00000000;
		if (REG_RD) begin
			unique case (REG_ADDR)
				`REG_CTRL: next_rdata = {28'h0000000, state != S_IDLE,
					locked, accepted, rb_sync};
				`REG_ADDR: next_rdata = {12'h000, addr_reg};
				`REG_WDATA: next_rdata = {24'h000000, wdata_reg};
				`REG_RESULT: next_rdata = {24'h000000, result};
				`REG_IRQ_STAT: next_rdata = {29'h0, irq_st};
				`REG_IRQ_MASK: next_rdata = {29'h0, mask};
				default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= S_IDLE;
			addr_reg <= 20'h00000;
			wdata_reg <= 8'h00;
			mask <= `IRQ_MASK_RESET;
			op_addr <= 20'h00000;
			bus_wdata <= 8'h00;
			result <= 8'h00;
			cnt <= 10'h000;
			go <= 1'b0;
			go_wr <= 1'b0;
			locked <= 1'b0;
			accepted <= 1'b0;
			prev_tog <= 1'b0;
			fail_seen <= 1'b0;
			pre_low <= 1'b0;
			rst_n_q <= 1'b1;
			irq_st <= '0;
			IRQ <= 1'b0;
			REG_RDATA <= 32'h00000000;
			rb_meta <= 1'b0;
			rb_sync <= 1'b0;
		end else begin
			state <= next_state;
			addr_reg <= next_addr_reg;
			wdata_reg <= next_wdata_reg;
			mask <= next_mask;
			op_addr <= next_op_addr;
			bus_wdata <= next_bus_wdata;
			result <= next_result;
			cnt <= next_cnt;
			go <= next_go;
			go_wr <= next_go_wr;
			locked <= next_locked;
			accepted <= next_accepted;
			prev_tog <= next_prev_tog;
			fail_seen <= next_fail_seen;
			pre_low <= next_pre_low;
			rst_n_q <= next_rst_n_q;
			irq_st <= next_irq_st;
			IRQ <= next_irq;
			REG_RDATA <= next_rdata;
			rb_meta <= READY_BUSY_OUT;
			rb_sync <= rb_meta;
		end
	end

	assign FLASH_RESET_N = rst_n_q;

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESETN);

	sequence s_toggle_same;
		state == S_POLL_NEXT && bus_done && bus_rdata[`TOGGLE_BIT] == prev_tog;
	endsequence
	sequence s_rst_enter;
		$fell(rst_n_q);
	endsequence

	poll_addr_stable_a: assert property (
		state inside {S_POLL_NEXT, S_FINAL} |-> $stable(op_addr))
		else $error("poll address moved during operation");
	extra_read_a: assert property (
		s_toggle_same |=> state == S_FINAL && go ##1 !go)
		else $error("no extra read after toggle stopped");
	still_toggling_a: assert property (
		state == S_POLL_NEXT && bus_done
		&& bus_rdata[`TOGGLE_BIT] != prev_tog |=> state != S_FINAL)
		else $error("completion taken while toggle still alternates");
	lock_refuse_a: assert property (
		state == S_IDLE && locked && ctrl_wr && op != OP_RESET
		|=> state == S_IDLE && irq_st[`IRQ_REJECT])
		else $error("command taken while failure lock set");
	reset_pulse_a: assert property (
		s_rst_enter |-> !rst_n_q [*8])
		else $error("flash reset pulse too short");
	add_accept_a: assert property (
		state == S_ADD_POST && bus_done
		|=> accepted == (pre_low && !$past(bus_rdata[`TIMER_BIT])))
		else $error("sector acceptance misjudged");
	irq_level_a: assert property (
		(|(irq_st & mask)) |=> IRQ)
		else $error("interrupt missing for unmasked status");

endmodule // flash_host_ctrl
`default_nettype wire

/* verification/flash_dev_model.sv */
/*
 Behavioural parallel flash with status flags, 16 bytes of array.
 Assumes the host keeps each strobe clean; 30h erases or resumes, B0h
 suspends an erase.
*/
`timescale 1ns/1ps
`default_nettype none

module flash_dev_model (
	input wire logic [19:0] addr,
	input wire logic [7:0] din,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	output logic [7:0] dout,
	output logic ready_busy
);
	logic [7:0] mem [16];
	logic [7:0] pdata = 8'h00;
	logic [7:0] last = 8'h00;
	logic [3:0] faddr = 4'h0;
	logic fail = 1'b0;
	logic tog = 1'b0;
	logic etog = 1'b0;
	logic erasing = 1'b0;
	logic susp = 1'b0;
	int pbusy = 0;
	int ereads = 0;
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
	end
	// Released bus shows the inverse so a stale byte never passes
	assign dout = (!ce_n && !oe_n) ? last : ~last;
	assign ready_busy = !(fail || pbusy != 0
		|| (erasing && !susp));
	always @(posedge we_n) begin
		if (!ce_n && reset_n) begin
			if (din == 8'h30) begin
				if (susp) begin
					susp = 1'b0;
				end else if (!erasing || ereads < 2) begin
					erasing = 1'b1;
					ereads = 0;
				end
			end else if (din == 8'hB0) begin
				susp = erasing;
			end else if (!fail && pbusy == 0 && (!erasing || susp)) begin
				pdata = din;
				if ((din & ~mem[addr[3:0]]) != 8'h00) begin
					fail = 1'b1;
					faddr = addr[3:0];
				end else
					mem[addr[3:0]] = mem[addr[3:0]] & din;
				pbusy = 3;
			end
		end
	end
	always @(negedge oe_n) begin
		if (!ce_n) begin
			if (fail) begin
				// Second toggle moves only on the failed location
				last = {~pdata[7], tog, 3'h4,
					(addr[3:0] == faddr) && etog, 2'h0};
				if (addr[3:0] == faddr)
					etog = ~etog;
				tog = ~tog;
			end else if (pbusy != 0) begin
				last = {~pdata[7], tog, 3'h0, susp, 2'h0};
				tog = ~tog;
				pbusy--;
			end else if (erasing && !susp) begin
				last = {1'b0, tog, 2'h0, (ereads >= 2), etog, 2'h0};
				tog = ~tog;
				etog = ~etog;
				ereads++;
				if (ereads == 6) begin
					erasing = 1'b0;
					foreach (mem[i]) mem[i] = 8'hFF;
				end
			end else
				last = mem[addr[3:0]];
		end
	end
	always @(negedge reset_n) begin
		fail = 1'b0;
		pbusy = 0;
		erasing = 1'b0;
		susp = 1'b0;
	end
endmodule // flash_dev_model

`default_nettype wire

/* verification/flash_host_ctrl_bench.sv */
/*
 Self-checking bench for the flash status-polling controller.
 Assumes the behavioural flash model on the pins and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_cfg.svh"

module flash_host_ctrl_bench import flash_host_pkg::*; ();
	logic SYS_CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [7:0] REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	logic [31:0] REG_RDATA;
	logic IRQ;
	logic [19:0] f_addr;
	logic [7:0] dq_out, dq_in, dev_dq;
	logic dq_oe, ce_n, oe_n, we_n, rst_n, rb;
	int failures = 0;
	int n_checks = 0;

	always #12.5 SYS_CLK = ~SYS_CLK;
	assign dq_in = dq_oe ? dq_out : dev_dq;

	flash_host_ctrl flash_host_ctrl_i (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
		.FLASH_ADDR(f_addr), .FLASH_DQ_IN(dq_in), .FLASH_DQ_OUT(dq_out),
		.FLASH_DQ_OE(dq_oe), .FLASH_CE_N(ce_n), .FLASH_OE_N(oe_n),
		.FLASH_WE_N(we_n), .FLASH_RESET_N(rst_n), .READY_BUSY_OUT(rb));
	flash_dev_model flash_dev_model_i (.addr(f_addr), .din(dq_out),
		.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n),
		.dout(dev_dq), .ready_busy(rb));

	task automatic end_sim;
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask

	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] m, e);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1 chk(nm, e, REG_RDATA & m);
	endtask

	// Runs one operation and expects exactly the given status bits
	task automatic op(input op_t c, input logic [19:0] a,
		input logic [7:0] d, input logic [2:0] e);
		int i;
		wr(`REG_ADDR, {12'h000, a});
		wr(`REG_WDATA, {24'h000000, d});
		wr(`REG_CTRL, {29'h0, c});
		i = 0;
		while (IRQ !== 1'b1 && i < 2000) begin
			@(posedge SYS_CLK);
			i++;
		end
		chk("irq_wait", 32'h0, {31'h0, i == 2000});
		rd("irq_stat", `REG_IRQ_STAT, 32'h7, {29'h0, e});
		wr(`REG_IRQ_STAT, 32'h7);
		repeat (3) @(posedge SYS_CLK);
		#1 chk("irq", 32'h0, {31'h0, IRQ});
	endtask

	initial begin
		repeat (2) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		rd("ctrl", `REG_CTRL, 32'hFFFFFFFF, 32'h1);
		rd("mask", `REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		rd("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
		// Masked done must stay off the interrupt line
		wr(`REG_CTRL, {29'h0, OP_READ});
		repeat (40) @(posedge SYS_CLK);
		#1 chk("irq_masked", 32'h0, {31'h0, IRQ});
		rd("irq_stat", `REG_IRQ_STAT, 32'h7, 32'h1);
		rd("result", `REG_RESULT, 32'hFF, 32'hFF);
		// Clear first, or the stale done ends the next wait at once
		wr(`REG_IRQ_STAT, 32'h7);
		wr(`REG_IRQ_MASK, 32'h7);
		op(OP_WRITE, 20'h5, 8'h5A, 3'h1);
		op(OP_POLL, 20'h5, 8'h00, 3'h1);
		rd("result", `REG_RESULT, 32'hFF, 32'h5A);
		op(OP_WRITE, 20'h8, 8'h30, 3'h1);
		op(OP_ADD_SECTOR, 20'h9, 8'h00, 3'h1);
		rd("accepted", `REG_CTRL, 32'h2, 32'h2);
		op(OP_READ, 20'h8, 8'h00, 3'h1);
		op(OP_READ, 20'h8, 8'h00, 3'h1);
		op(OP_ADD_SECTOR, 20'h9, 8'h00, 3'h4);
		rd("accepted", `REG_CTRL, 32'h2, 32'h0);
		op(OP_POLL, 20'h8, 8'h00, 3'h1);
		rd("result", `REG_RESULT, 32'hFF, 32'hFF);
		// Suspend an erase, program elsewhere, then resume it
		op(OP_WRITE, 20'h8, 8'h30, 3'h1);
		op(OP_WRITE, 20'h8, 8'hB0, 3'h1);
		rd("rb_susp", `REG_CTRL, 32'h1, 32'h1);
		op(OP_WRITE, 20'h2, 8'h0F, 3'h1);
		rd("rb_busy", `REG_CTRL, 32'h1, 32'h0);
		op(OP_READ, 20'h2, 8'h00, 3'h1);
		rd("susp_prog", `REG_RESULT, 32'h84, 32'h84);
		op(OP_POLL, 20'h2, 8'h00, 3'h1);
		rd("result", `REG_RESULT, 32'hFF, 32'h0F);
		op(OP_WRITE, 20'h8, 8'h30, 3'h1);
		op(OP_POLL, 20'h8, 8'h00, 3'h1);
		rd("result", `REG_RESULT, 32'hFF, 32'hFF);
		op(OP_WRITE, 20'h5, 8'h0F, 3'h1);
		op(OP_POLL, 20'h5, 8'h00, 3'h1);
		op(OP_WRITE, 20'h5, 8'hF0, 3'h1);
		op(OP_POLL, 20'h5, 8'h00, 3'h2);
		rd("locked", `REG_CTRL, 32'h4, 32'h4);
		op(OP_READ, 20'h5, 8'h00, 3'h4);
		op(OP_RESET, 20'h0, 8'h00, 3'h1);
		rd("locked", `REG_CTRL, 32'h4, 32'h0);
		op(OP_READ, 20'h5, 8'h00, 3'h1);
		rd("result", `REG_RESULT, 32'hFF, 32'h0F);
		end_sim;
	end

	// Whole run is a few thousand cycles; this leaves ample margin
	initial begin
		#(20000 * 25);
		failures++;
		end_sim;
	end
endmodule // flash_host_ctrl_bench

`default_nettype wire
